// File: include/lic_defines.svh
// Purpose: constants of the level interrupt controller
// Assumes: register file addresses are set 0 locations
// Notes:   bank select, offsets, field positions and reset values only
`ifndef LIC_DEFINES_SVH
`define LIC_DEFINES_SVH

// ==========================================================
// register locations, bank 0
`define LIC_BANK_SEL     1'b0
`define LIC_ADDR_REQ     8'hDC
`define LIC_ADDR_MASK    8'hDD
`define LIC_ADDR_SYM     8'hDE
`define LIC_ADDR_PRIO    8'hFF
`define LIC_ADDR_P0_EN   8'hF1
`define LIC_ADDR_P0_PND  8'hF2
`define LIC_ADDR_P2_EN   8'hE5
`define LIC_ADDR_P2_PND  8'hE6

// ==========================================================
// system mode fields
`define LIC_SYM_GIE      0
`define LIC_SYM_FAST_EN  1
`define LIC_SYM_FAST_LO  2
`define LIC_SYM_FAST_HI  4
`define LIC_SYM_EXT      7

// ==========================================================
// level priority fields
`define LIC_IPR_A        0
`define LIC_IPR_ORD0     1
`define LIC_IPR_B        2
`define LIC_IPR_BSUB     3
`define LIC_IPR_ORD1     4
`define LIC_IPR_C        5
`define LIC_IPR_CSUB     6
`define LIC_IPR_ORD2     7

// ==========================================================
// hardware-cleared pending slots
`define LIC_HW_T0        0
`define LIC_HW_T1        1
`define LIC_HW_T2        2
`define LIC_HW_CTRA      3

// ==========================================================
// reset values
`define LIC_RST_BYTE     8'h00
`define LIC_RST_FAST     3'h0
`define LIC_RST_HW       4'h0

`endif

// File: include/lic_pkg.sv
// Purpose: shared types of the level interrupt controller
// Assumes: eight levels, up to four sources per level
// Notes:   numbers live in lic_defines.svh
package lic_pkg;
  typedef logic [7:0] lic_byte_t;
  typedef logic [2:0] lic_lvl_t;
  typedef logic [1:0] lic_src_t;
  typedef logic [3:0] lic_srcs_t;
  // group orderings chosen by the three order bits
  typedef enum {
    LIC_ORD_ABC, LIC_ORD_BCA, LIC_ORD_BAC,
    LIC_ORD_CAB, LIC_ORD_CBA, LIC_ORD_ACB
  } lic_order_t;
endpackage

// File: verilog/lic_level_src.sv
// Purpose: fixed-order source pick inside one level
// Assumes: bit 0 is the lowest vector address
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module lic_level_src
  import lic_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reset,
  input  wire lic_srcs_t req,
  output logic           any,
  output lic_src_t       idx
);
  // lowest index wins; fixed in hardware
  always_comb begin
    any = |req;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin
        idx = i[1:0];
      end
    end
  end

  AST_LOWEST: assert property (@(posedge sys_clk) disable iff (reset)
    any |-> req[idx] && ((req & ((4'h1 << idx) - 4'h1)) == 4'h0))
    else $error("source pick is not the lowest vector");
endmodule // lic_level_src
`default_nettype wire

// File: verilog/lic_group_arb.sv
// Purpose: level priority resolution by groups
// Assumes: lvl_req already gated by the level mask
// Notes:   order-bit codes 000 and 111 fall back to A>B>C
`timescale 1ns/100ps
`default_nettype none
`include "lic_defines.svh"
module lic_group_arb
  import lic_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reset,
  input  wire lic_byte_t lvl_req,
  input  wire lic_byte_t level_priority_reg,
  output logic           win_valid,
  output lic_lvl_t       win_lvl
);
  logic       a_v, b_v, c_v, s34, s67;
  lic_lvl_t   a_l, b_l, c_l, l34, l67;
  lic_order_t ord;

  // winners inside each group
  always_comb begin
    a_v = lvl_req[0] | lvl_req[1];
    a_l = (lvl_req[0] & lvl_req[1]) ? (level_priority_reg[`LIC_IPR_A] ? 3'h1 : 3'h0)
        : (lvl_req[1] ? 3'h1 : 3'h0);
    s34 = lvl_req[3] | lvl_req[4];
    l34 = (lvl_req[3] & lvl_req[4]) ? (level_priority_reg[`LIC_IPR_BSUB] ? 3'h4 : 3'h3)
        : (lvl_req[4] ? 3'h4 : 3'h3);
    b_v = lvl_req[2] | s34;
    b_l = (lvl_req[2] & s34) ? (level_priority_reg[`LIC_IPR_B] ? l34 : 3'h2)
        : (lvl_req[2] ? 3'h2 : l34);
    s67 = lvl_req[6] | lvl_req[7];
    l67 = (lvl_req[6] & lvl_req[7]) ? (level_priority_reg[`LIC_IPR_CSUB] ? 3'h7 : 3'h6)
        : (lvl_req[7] ? 3'h7 : 3'h6);
    c_v = lvl_req[5] | s67;
    c_l = (lvl_req[5] & s67) ? (level_priority_reg[`LIC_IPR_C] ? l67 : 3'h5)
        : (lvl_req[5] ? 3'h5 : l67);
  end

  // group order from the three scattered order bits
  always_comb begin
    case ({level_priority_reg[`LIC_IPR_ORD2], level_priority_reg[`LIC_IPR_ORD1], level_priority_reg[`LIC_IPR_ORD0]})
      3'h1:    ord = LIC_ORD_BCA;
      3'h2:    ord = LIC_ORD_ABC;
      3'h3:    ord = LIC_ORD_BAC;
      3'h4:    ord = LIC_ORD_CAB;
      3'h5:    ord = LIC_ORD_CBA;
      3'h6:    ord = LIC_ORD_ACB;
      default: ord = LIC_ORD_ABC;
    endcase
  end

  // first present group in the chosen order wins
  always_comb begin
    win_valid = a_v | b_v | c_v;
    win_lvl   = 3'h0;
    case (ord)
      LIC_ORD_BCA: win_lvl = b_v ? b_l : (c_v ? c_l : a_l);
      LIC_ORD_BAC: win_lvl = b_v ? b_l : (a_v ? a_l : c_l);
      LIC_ORD_CAB: win_lvl = c_v ? c_l : (a_v ? a_l : b_l);
      LIC_ORD_CBA: win_lvl = c_v ? c_l : (b_v ? b_l : a_l);
      LIC_ORD_ACB: win_lvl = a_v ? a_l : (c_v ? c_l : b_l);
      default:     win_lvl = a_v ? a_l : (b_v ? b_l : c_l);
    endcase
  end

  AST_WIN_REQ: assert property (@(posedge sys_clk) disable iff (reset)
    win_valid |-> lvl_req[win_lvl])
    else $error("winner level is not requesting");
  // whenever group A wins with both its levels up, the preferred one wins
  AST_GROUP_A: assert property (@(posedge sys_clk) disable iff (reset)
    (lvl_req[1:0] == 2'h3) && (win_lvl < 3'h2)
    |-> win_lvl == (level_priority_reg[`LIC_IPR_A] ? 3'h1 : 3'h0))
    else $error("group A order wrong");
endmodule // lic_group_arb
`default_nettype wire

// File: verilog/lic_top.sv
// Purpose: system-level interrupt controller, eight levels
// Assumes: register port and CPU strobes synchronous to sys_clk
// Notes:   match/serial/timer pending bits live in their peripherals
`timescale 1ns/100ps
`default_nettype none
`include "lic_defines.svh"
module lic_top
  import lic_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reset,
  input  wire logic      clk_en,
  // register port from the CPU
  input  wire logic      reg_bank,
  input  wire lic_byte_t reg_addr,
  input  wire logic      reg_wr,
  input  wire lic_byte_t reg_wdata,
  input  wire logic      reg_rd,
  output lic_byte_t      reg_rdata,
  // instruction strobes and acknowledge
  input  wire logic      global_enable_instr,
  input  wire logic      global_disable_instr,
  input  wire logic      interrupt_return_instr,
  input  wire logic      irq_ack,
  output logic           irq_req,
  output lic_lvl_t       irq_level,
  output lic_src_t       irq_src,
  output logic           global_enable,
  output logic           fast_enable,
  output lic_lvl_t       fast_level,
  // timer sources
  input  wire logic      t0_ovf_evt,
  input  wire logic      t0_ovf_en,
  input  wire logic      t0_mc_pnd,
  input  wire logic      t0_mc_en,
  input  wire logic      t1_ovf_evt,
  input  wire logic      t1_ovf_en,
  input  wire logic      t1_mc_pnd,
  input  wire logic      t1_mc_en,
  input  wire logic      t2_ovf_evt,
  input  wire logic      t2_ovf_en,
  input  wire logic      t2_mc_pnd,
  input  wire logic      t2_mc_en,
  // level 2 sources
  input  wire logic      ctra_evt,
  input  wire logic      ctra_en,
  input  wire logic      frt_pnd,
  input  wire logic      frt_en,
  input  wire logic      spi_pnd,
  input  wire logic      spi_en,
  // port pin events, one-cycle pulses
  input  wire lic_byte_t p0_evt,
  input  wire lic_byte_t p2_evt
);

  // ==========================================================
  // state
  lic_byte_t mask_q;
  lic_byte_t prio_q;
  logic      gie_q, gie_d;
  logic      fast_en_q;
  lic_lvl_t  fast_lvl_q;
  logic      ext_ctl_q;
  lic_byte_t req_lvl_q;
  lic_byte_t p0_en_q, p0_pnd_q;
  lic_byte_t p2_en_q, p2_pnd_q;
  logic [3:0] hwp_q;
  logic      irq_req_q;
  lic_lvl_t  irq_lvl_q;
  lic_src_t  irq_src_q;
  lic_byte_t rdata_q;

  // ==========================================================
  // decode
  logic      wr_ok, rd_ok, ack_take;
  logic      wr_mask, wr_sym, wr_prio;
  logic      wr_p0e, wr_p0p, wr_p2e, wr_p2p;

  assign wr_ok    = clk_en & reg_wr & (reg_bank == `LIC_BANK_SEL);
  assign rd_ok    = clk_en & reg_rd & (reg_bank == `LIC_BANK_SEL);
  assign ack_take = clk_en & irq_ack & irq_req_q;

  // write strobes; the request register has none, so writes fall away
  always_comb begin
    wr_mask = 1'b0;
    wr_sym  = 1'b0;
    wr_prio = 1'b0;
    wr_p0e  = 1'b0;
    wr_p0p  = 1'b0;
    wr_p2e  = 1'b0;
    wr_p2p  = 1'b0;
    if (!wr_ok) begin
      wr_mask = 1'b0;
    end else if (reg_addr == `LIC_ADDR_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_addr == `LIC_ADDR_SYM) begin
      wr_sym = 1'b1;
    end else if (reg_addr == `LIC_ADDR_PRIO) begin
      wr_prio = 1'b1;
    end else if (reg_addr == `LIC_ADDR_P0_EN) begin
      wr_p0e = 1'b1;
    end else if (reg_addr == `LIC_ADDR_P0_PND) begin
      wr_p0p = 1'b1;
    end else if (reg_addr == `LIC_ADDR_P2_EN) begin
      wr_p2e = 1'b1;
    end else if (reg_addr == `LIC_ADDR_P2_PND) begin
      wr_p2p = 1'b1;
    end
  end

  // ==========================================================
  // mask and priority: content undefined by contract, zeroed anyway
  // so the outputs never carry unknowns out of reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_q <= `LIC_RST_BYTE;
    end else if (wr_mask) begin
      mask_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prio_q <= `LIC_RST_BYTE;
    end else if (wr_prio) begin
      prio_q <= reg_wdata;
    end
  end

  // ==========================================================
  // global enable: acceptance beats disable beats enable/return
  always_comb begin
    gie_d = gie_q;
    if (!clk_en) begin
      gie_d = gie_q;
    end else if (ack_take) begin
      gie_d = 1'b0;
    end else if (global_disable_instr) begin
      gie_d = 1'b0;
    end else if (global_enable_instr | interrupt_return_instr) begin
      gie_d = 1'b1;
    end else if (wr_sym) begin
      gie_d = reg_wdata[`LIC_SYM_GIE];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gie_q <= 1'b0;
    end else begin
      gie_q <= gie_d;
    end
  end

  // other mode bits; external control is held but drives nothing
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fast_en_q <= 1'b0;
      ext_ctl_q <= 1'b0;
    end else if (wr_sym) begin
      fast_en_q <= reg_wdata[`LIC_SYM_FAST_EN];
      ext_ctl_q <= reg_wdata[`LIC_SYM_EXT];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fast_lvl_q <= `LIC_RST_FAST;
    end else if (wr_sym) begin
      fast_lvl_q <= reg_wdata[`LIC_SYM_FAST_HI:`LIC_SYM_FAST_LO];
    end
  end

  // ==========================================================
  // port enables and pending; a zero write clears, a new edge wins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      p0_en_q <= `LIC_RST_BYTE;
      p2_en_q <= `LIC_RST_BYTE;
    end else begin
      if (wr_p0e) begin
        p0_en_q <= reg_wdata;
      end
      if (wr_p2e) begin
        p2_en_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      p0_pnd_q <= `LIC_RST_BYTE;
      p2_pnd_q <= `LIC_RST_BYTE;
    end else if (clk_en) begin
      p0_pnd_q <= (wr_p0p ? (p0_pnd_q & reg_wdata) : p0_pnd_q) | p0_evt;
      p2_pnd_q <= (wr_p2p ? (p2_pnd_q & reg_wdata) : p2_pnd_q) | p2_evt;
    end
  end

  // ==========================================================
  // hardware-cleared pending: cleared when its own request is taken
  logic [3:0] hw_evt, hw_clr;
  assign hw_evt = {ctra_evt, t2_ovf_evt, t1_ovf_evt, t0_ovf_evt};

  always_comb begin
    hw_clr = 4'h0;
    if (ack_take) begin
      hw_clr[`LIC_HW_T0] = (irq_lvl_q == 3'h0) && (irq_src_q == 2'h0);
      hw_clr[`LIC_HW_T1] = (irq_lvl_q == 3'h1) && (irq_src_q == 2'h0);
      hw_clr[`LIC_HW_T2] = (irq_lvl_q == 3'h3) && (irq_src_q == 2'h0);
      hw_clr[`LIC_HW_CTRA] = (irq_lvl_q == 3'h2) && (irq_src_q == 2'h1);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hwp_q <= `LIC_RST_HW;
    end else if (clk_en) begin
      hwp_q <= (hwp_q & ~hw_clr) | hw_evt;
    end
  end

  // ==========================================================
  // per-level source vectors, bit 0 = lowest vector address
  lic_srcs_t lsrc [8];
  logic [7:0] lany;
  lic_src_t   lidx [8];

  always_comb begin
    lsrc[0] = {2'h0, t0_mc_pnd & t0_mc_en,
               hwp_q[`LIC_HW_T0] & t0_ovf_en};
    lsrc[1] = {2'h0, t1_mc_pnd & t1_mc_en,
               hwp_q[`LIC_HW_T1] & t1_ovf_en};
    lsrc[2] = {1'b0, frt_pnd & frt_en,
               hwp_q[`LIC_HW_CTRA] & ctra_en, spi_pnd & spi_en};
    lsrc[3] = {2'h0, t2_mc_pnd & t2_mc_en,
               hwp_q[`LIC_HW_T2] & t2_ovf_en};
    lsrc[4] = p2_pnd_q[3:0] & p2_en_q[3:0];
    lsrc[5] = p2_pnd_q[7:4] & p2_en_q[7:4];
    lsrc[6] = p0_pnd_q[3:0] & p0_en_q[3:0];
    lsrc[7] = p0_pnd_q[7:4] & p0_en_q[7:4];
  end

  // one fixed-order picker per level
  for (genvar g = 0; g < 8; g++) begin : g_lvl
    lic_level_src u_src (
      .sys_clk (sys_clk),
      .reset   (reset),
      .req     (lsrc[g]),
      .any     (lany[g]),
      .idx     (lidx[g])
    );
  end

  // ==========================================================
  // level gating and priority
  lic_byte_t lvl_req;
  logic      win_valid;
  lic_lvl_t  win_lvl;

  assign lvl_req = lany & mask_q;

  lic_group_arb u_arb (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .lvl_req   (lvl_req),
    .level_priority_reg       (prio_q),
    .win_valid (win_valid),
    .win_lvl   (win_lvl)
  );

  // request register shows level requests whatever the mask
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_lvl_q <= `LIC_RST_BYTE;
    end else if (clk_en) begin
      req_lvl_q <= lany;
    end
  end

  // offer refreshed every clk_en cycle; tracks gie_d so a disable or an
  // acceptance withdraws it on the same edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_req_q <= 1'b0;
      irq_lvl_q <= 3'h0;
      irq_src_q <= 2'h0;
    end else if (clk_en) begin
      irq_req_q <= gie_d & win_valid;
      irq_lvl_q <= win_lvl;
      irq_src_q <= lidx[win_lvl];
    end
  end

  // ==========================================================
  // read path, one cycle latency; unused bits and holes read zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= `LIC_RST_BYTE;
    end else if (rd_ok) begin
      if (reg_addr == `LIC_ADDR_REQ) begin
        rdata_q <= req_lvl_q;
      end else if (reg_addr == `LIC_ADDR_MASK) begin
        rdata_q <= mask_q;
      end else if (reg_addr == `LIC_ADDR_SYM) begin
        rdata_q <= {ext_ctl_q, 2'h0, fast_lvl_q,
                    fast_en_q, gie_q};
      end else if (reg_addr == `LIC_ADDR_PRIO) begin
        rdata_q <= prio_q;
      end else if (reg_addr == `LIC_ADDR_P0_EN) begin
        rdata_q <= p0_en_q;
      end else if (reg_addr == `LIC_ADDR_P0_PND) begin
        rdata_q <= p0_pnd_q;
      end else if (reg_addr == `LIC_ADDR_P2_EN) begin
        rdata_q <= p2_en_q;
      end else if (reg_addr == `LIC_ADDR_P2_PND) begin
        rdata_q <= p2_pnd_q;
      end else begin
        rdata_q <= `LIC_RST_BYTE;
      end
    end
  end

  assign reg_rdata     = rdata_q;
  assign irq_req       = irq_req_q;
  assign irq_level     = irq_lvl_q;
  assign irq_src       = irq_src_q;
  assign global_enable = gie_q;
  assign fast_enable   = fast_en_q;
  assign fast_level    = fast_lvl_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_take;
    ack_take;
  endsequence
  sequence s_enable;
    clk_en && global_enable_instr && !global_disable_instr && !ack_take;
  endsequence

  AST_EI_SETS: assert property (s_enable |=> gie_q)
    else $error("enable instruction did not set global enable");
  AST_DI_CLRS: assert property (clk_en && global_disable_instr |=> !gie_q)
    else $error("disable instruction did not clear global enable");
  AST_ACK_CLRS: assert property (s_take |=> !gie_q && !irq_req_q)
    else $error("acceptance left interrupts enabled");
  AST_INTERRUPT_RETURN_INSTR_SETS: assert property (clk_en && interrupt_return_instr
    && !global_disable_instr && !ack_take |=> gie_q)
    else $error("return did not re-enable");
  AST_REQ_GATED: assert property (irq_req_q |-> gie_q
    && mask_q[irq_lvl_q])
    else $error("offer without enable or mask");
  AST_DIRECT_WR: assert property (clk_en && wr_sym && !ack_take
    && !global_disable_instr && !global_enable_instr
    && !interrupt_return_instr |=> gie_q == $past(reg_wdata[0]))
    else $error("direct write to global enable ignored");
  AST_REQ_REG: assert property (clk_en |=> req_lvl_q == $past(lany))
    else $error("request register mismatch");
  AST_PORT0_MAP: assert property (lany[7] == |(p0_pnd_q[7:4]
    & p0_en_q[7:4]))
    else $error("port 0 upper nibble not on level 7");
  AST_SYM_UNUSED: assert property (rd_ok && reg_addr == `LIC_ADDR_SYM
    |=> reg_rdata[6:5] == 2'h0)
    else $error("unused mode bits read nonzero");
  AST_HW_CLEAR: assert property (s_take ##0 (hw_clr[`LIC_HW_T0]
    && !t0_ovf_evt) |=> !hwp_q[`LIC_HW_T0])
    else $error("overflow pending not cleared on acceptance");
  AST_RESET_SYM: assert property (@(posedge sys_clk) disable iff (1'b0)
    $fell(reset) |-> !gie_q && !fast_en_q && !ext_ctl_q)
    else $error("mode bits not cleared by reset");
endmodule // lic_top
`default_nettype wire

// File: tb/lic_cpu_model.sv
// Purpose: stand-in for the CPU sequencer that takes offers
// Assumes: strobes change just after the rising edge, except that slow raises irq_ack on the edge itself
// Notes:   slow waits three cycles before accepting
`timescale 1ns/100ps
`default_nettype none
module lic_cpu_model (
  input  wire logic sys_clk,
  input  wire logic irq_req,
  input  wire logic slow,
  output logic      irq_ack,
  output logic      ret_instr
);
  // ==========================================================
  // accept
  // the routine is short, so return comes a few cycles later
  initial begin
    irq_ack = 1'b0;
    ret_instr = 1'b0;
    forever begin
      @(posedge sys_clk);
      #1;
      if (irq_req) begin
        repeat (slow ? 3 : 0) @(posedge sys_clk);
        irq_ack = 1'b1;
        @(posedge sys_clk);
        #1;
        irq_ack = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        ret_instr = 1'b1;
        @(posedge sys_clk);
        #1;
        ret_instr = 1'b0;
      end
    end
  end
endmodule // lic_cpu_model
`default_nettype wire

// File: tb/level_interrupt_controller_tb.sv
// Purpose: self-checking bench for the level interrupt controller
// Assumes: read data answers one cycle after the strobe
// Notes:   results are matched against a queue of expected bytes
`timescale 1ns/100ps
`default_nettype none
module level_interrupt_controller_tb
  import lic_pkg::*;
;
  logic      sys_clk, reset, clk_en, reg_bank, reg_wr, reg_rd, slow;
  lic_byte_t reg_addr, reg_wdata, reg_rdata, p0_evt, p2_evt, m, e;
  logic      global_enable_instr, global_disable_instr, src_en, rd_d;
  logic      interrupt_return_instr, irq_ack, irq_req;
  logic      t0_ovf_evt, t0_mc_pnd, t1_ovf_evt, t1_mc_pnd, t1_mc_en;
  logic      t2_ovf_evt, ctra_evt, spi_pnd, t0_mc_en, ge, fe;
  logic      t2_mc_pnd, t2_mc_en, frt_pnd, frt_en;
  logic [1:0] p;
  lic_lvl_t  irq_level, fl;
  lic_src_t  irq_src;
  lic_byte_t exp_q[$];
  int        err_total, checks_done, cyc, acks_seen, acks_want;
  lic_byte_t ipr_v[4] = '{8'h00, 8'h01, 8'h02, 8'h0C};
  logic [31:0] ord_v[4] = '{32'h0004090C, 32'h0400090C, 32'h090C0004,
                            32'h00040C09};

  lic_top dut (
    .sys_clk, .reset, .clk_en, .reg_bank, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .global_enable_instr, .global_disable_instr,
    .interrupt_return_instr, .irq_ack, .irq_req, .irq_level, .irq_src,
    .global_enable(ge), .fast_enable(fe), .fast_level(fl),
    .t0_ovf_evt, .t0_ovf_en(src_en), .t0_mc_pnd, .t0_mc_en,
    .t1_ovf_evt, .t1_ovf_en(src_en), .t1_mc_pnd, .t1_mc_en,
    .t2_ovf_evt, .t2_ovf_en(src_en), .t2_mc_pnd, .t2_mc_en,
    .ctra_evt, .ctra_en(src_en), .frt_pnd, .frt_en,
    .spi_pnd, .spi_en(src_en), .p0_evt, .p2_evt
  );

  lic_cpu_model cpu (.sys_clk, .irq_req, .slow, .irq_ack,
                     .ret_instr(interrupt_return_instr));

  // ==========================================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================
  // tasks
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(lic_byte_t seen, lic_byte_t exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // an idle cycle after each access keeps strobes from being re-raised
  task automatic wr(lic_byte_t a, lic_byte_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask

  task automatic rd(lic_byte_t a, lic_byte_t x);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(x);
    tick();
    reg_rd = 1'b0;
    tick();
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask

  // running totals: an acceptance that lands inside the stimulus task
  // before this is called still counts
  task automatic wait_acks(int n);
    acks_want += n;
    repeat (300) begin
      if (acks_seen >= acks_want) break;
      @(posedge sys_clk);
    end
    #1;
    if (acks_seen < acks_want) check(8'(acks_seen), 8'(acks_want));
  endtask

  // ==========================================================
  // monitor: read data and accepted offers, oldest note first
  always @(posedge sys_clk) begin
    if (rd_d) check(reg_rdata, exp_q.pop_front());
    if (irq_ack && irq_req) begin
      acks_seen++;
      if (exp_q.size() == 0) check({3'h0, irq_level, irq_src}, 8'hEE);
      else check({3'h0, irq_level, irq_src}, exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    {reg_bank, reg_wr, reg_rd, reg_addr, reg_wdata, slow} = '0;
    {t0_mc_en, t2_mc_pnd, t2_mc_en, frt_pnd, frt_en} = '0;
    {global_enable_instr, global_disable_instr, src_en, t1_mc_en} = '0;
    {t0_ovf_evt, t0_mc_pnd, t1_ovf_evt, t1_mc_pnd, t2_ovf_evt} = '0;
    {ctra_evt, spi_pnd, p0_evt, p2_evt} = '0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(56));
    tick(2);
    reset = 1'b0;
    tick();
    check({3'h0, ge, fe, fl}, 8'h00);
    // reset contents, plus two unmapped places
    foreach (ipr_v[i]) rd(8'hDC + 8'(i), 8'h00);
    rd(8'h80, 8'h00);
    m = 8'($urandom());
    p = 2'($urandom());
    wr(8'hDD, m);
    rd(8'hDD, m);
    clk_en = 1'b0;
    wr(8'hDD, ~m);
    clk_en = 1'b1;
    reg_bank = 1'b1;
    wr(8'hDD, ~m);
    reg_bank = 1'b0;
    rd(8'hDD, m);
    wr(8'hDC, 8'hFF);
    rd(8'hDC, 8'h00);
    wr(8'hDE, 8'hFE);
    rd(8'hDE, 8'h9E);
    check({4'h0, fe, fl}, 8'h0F);
    wr(8'hDE, 8'h00);
    pulse(global_enable_instr);
    check({7'h0, ge}, 8'h01);
    rd(8'hDE, 8'h01);
    pulse(global_disable_instr);
    check({7'h0, ge}, 8'h00);
    rd(8'hDE, 8'h00);
    wr(8'hDE, 8'h01);
    rd(8'hDE, 8'h01);
    wr(8'hDE, 8'h00);
    // level map, one level at a time, global enable off
    wr(8'hF1, 8'hFF);
    wr(8'hE5, 8'hFF);
    {src_en, t0_mc_en} = '1;
    // these stay pending, held back only by their own enables
    {t1_mc_pnd, t2_mc_pnd, frt_pnd} = '1;
    tick(2);
    rd(8'hDC, 8'h00);
    e = 8'h00;
    for (int l = 0; l < 8; l++) begin
      case (l)
        0: t0_ovf_evt = 1'b1;
        1: t1_mc_en = 1'b1;
        2: spi_pnd = 1'b1;
        3: t2_ovf_evt = 1'b1;
        4: p2_evt = 8'h01 << p;
        5: p2_evt = 8'h10 << p;
        6: p0_evt = 8'h01 << p;
        default: p0_evt = 8'h10 << p;
      endcase
      tick();
      {t0_ovf_evt, t2_ovf_evt, p0_evt, p2_evt} = '0;
      tick(2);
      e[l] = 1'b1;
      rd(8'hDC, e);
    end
    {t1_mc_pnd, spi_pnd} = '0;
    wr(8'hF2, 8'h00);
    wr(8'hE6, 8'h00);
    rd(8'hDC, 8'h09);
    wr(8'hDD, 8'hFF);
    wr(8'hFF, 8'h02);
    exp_q.push_back(8'h0C);
    exp_q.push_back(8'h00);
    pulse(global_enable_instr);
    wait_acks(2);
    tick(8);
    // priority rounds, prompt and slow acceptance
    for (int r = 0; r < 4; r++) begin
      slow = r[0];
      wr(8'hFF, ipr_v[r]);
      for (int k = 3; k >= 0; k--) exp_q.push_back(ord_v[r][8*k +: 8]);
      {t0_ovf_evt, t1_ovf_evt, t2_ovf_evt, ctra_evt} = '1;
      tick();
      {t0_ovf_evt, t1_ovf_evt, t2_ovf_evt, ctra_evt} = '0;
      wait_acks(4);
      rd(8'hDE, 8'h00);
      tick(8);
    end
    // a masked level waits, still visible in the request byte
    wr(8'hDD, 8'hFD);
    exp_q.push_back(8'h00);
    {t0_ovf_evt, t1_ovf_evt} = '1;
    tick();
    {t0_ovf_evt, t1_ovf_evt} = '0;
    wait_acks(1);
    tick(20);
    rd(8'hDC, 8'h02);
    exp_q.push_back(8'h04);
    wr(8'hDD, 8'hFF);
    wait_acks(1);
    tick(8);
    // two sources of one level: lowest vector first
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h01);
    t0_mc_pnd = 1'b1;
    t0_ovf_evt = 1'b1;
    tick();
    t0_ovf_evt = 1'b0;
    wait_acks(2);
    t0_mc_pnd = 1'b0;
    // long-held software pendings released by their source enables
    exp_q.push_back(8'h0D);
    exp_q.push_back(8'h0A);
    {t2_mc_en, frt_en} = '1;
    wait_acks(1);
    t2_mc_pnd = 1'b0;
    wait_acks(1);
    frt_pnd = 1'b0;
    tick(10);
    results();
  end
endmodule // level_interrupt_controller_tb
`default_nettype wire
